/* File: hdl/power_state_params.svh */
// Timing constants and encodings of the power state controller.
`ifndef POWER_STATE_PARAMS_SVH
`define POWER_STATE_PARAMS_SVH
`define CLOCK_HZ 25000000
`define WAKE_WINDOW_S 5
`define WAKE_WINDOW_CYCLES (`WAKE_WINDOW_S * `CLOCK_HZ)
`define SLEEP_DELAY_S 1
`define SLEEP_DELAY_CYCLES (`SLEEP_DELAY_S * `CLOCK_HZ)
`define RESET_MIN_S 1
`define RESET_MIN_CYCLES (`RESET_MIN_S * `CLOCK_HZ)
`define BUTTON_HOLD_S 8
`define BUTTON_HOLD_CYCLES (`BUTTON_HOLD_S * `CLOCK_HZ)
`define TIMER_WIDTH 28
`define RAIL_RESET 1'h0
`define PIN_IDLE_LEVELS 7'h24
`define HOST_LINK_RESET 4'hC
`endif

/* File: hdl/power_state_pkg.sv */
// Types shared by both ends of the power state controller.
package power_state_pkg;
	typedef enum logic [2:0] {
		ST_OFF,
		ST_WAKE_WAIT,
		ST_ACTIVE,
		ST_POWER_DOWN,
		ST_SLEEP,
		ST_RESET
	} power_state_t;
endpackage : power_state_pkg

/* File: hdl/power_hold_if.sv */
// Link between the power state controller and the host processor.
`timescale 1ns/1ns
`default_nettype none
interface power_hold_if;
	logic power_hold_request;
	logic wake_notify_n_out;
	logic wake_notify_n_oe;
	logic wake_notify_n;
	assign wake_notify_n = wake_notify_n_oe ? wake_notify_n_out : 1'b1;
	modport device (
		input power_hold_request,
		output wake_notify_n_out,
		output wake_notify_n_oe
	);
	modport host (
		output power_hold_request,
		input wake_notify_n
	);
endinterface : power_hold_if
`default_nettype wire

/* File: hdl/pin_sync.sv */
// Two-stage synchroniser with rising and falling edges decoded from its registers.
`timescale 1ns/1ns
`default_nettype none
module pin_sync (
	// Clock and reset.
	input wire logic CLOCK,
	input wire logic RESET_N,
	// Pin and result.
	input wire logic PIN,
	input wire logic RESET_LEVEL,
	output logic LEVEL,
	output logic RISE,
	output logic FALL
);
	typedef struct packed {
		logic seeded;
		logic meta;
		logic level;
		logic last;
	} sync_t;
	sync_t r;
	sync_t next_r;
	// Reset value is constant; the chosen idle level is applied after release.
	always_comb begin
		next_r = r;
		next_r.seeded = 1'b1;
		if (!r.seeded) begin
			next_r.meta = RESET_LEVEL;
			next_r.level = RESET_LEVEL;
			next_r.last = RESET_LEVEL;
		end else begin
			next_r.meta = PIN;
			next_r.level = r.meta;
			next_r.last = r.level;
		end
	end
	always_ff @(posedge CLOCK or negedge RESET_N) begin
		if (!RESET_N) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end
	assign LEVEL = r.level;
	assign RISE = r.seeded && r.level && !r.last;
	assign FALL = r.seeded && !r.level && r.last;
endmodule : pin_sync
`default_nettype wire

/* File: hdl/power_state_device.sv */
// Power state machine of the power-management device.
`timescale 1ns/1ns
`default_nettype none
`include "power_state_params.svh"
module power_state_device
	import power_state_pkg::*;
(
	// Clock and reset.
	input wire logic CLOCK,
	input wire logic RESET_N,
	// Host link.
	power_hold_if.device LINK,
	// Pins from the board.
	input wire logic PUSH_BUTTON_IN,
	input wire logic USB_INPUT,
	input wire logic WALL_ADAPTER_INPUT,
	input wire logic HARD_RESTART_N,
	// Supply and fault monitors.
	input wire logic UNDERVOLTAGE_LOCKOUT,
	input wire logic OVERTEMP_SHUTDOWN,
	input wire logic POWER_GOOD_FAIL,
	// Control bits and sequencer status.
	input wire logic SHUTDOWN_SELECT,
	input wire logic STANDBY_ENABLED,
	input wire logic SEQ_DOWN_DONE,
	input wire logic CHARGER_ENABLE_REQ,
	// Outputs to rails, sequencer and registers.
	output logic UNSEQUENCED_RAILS_ON,
	output logic STANDBY_REGULATOR,
	output logic SEQ_POWER_UP,
	output logic SEQ_POWER_DOWN,
	output logic REGISTERS_DEFAULT,
	output logic SERIAL_ENABLE,
	output logic CHARGER_ACTIVE,
	output power_state_t STATE
);
	typedef struct packed {
		power_state_t state;
		logic [`TIMER_WIDTH-1:0] timer;
		logic [`TIMER_WIDTH-1:0] button_timer;
		logic unseq_on;
		logic standby_on;
		logic notify_low;
		logic seq_up;
		logic fault_seen;
		logic regs_default;
	} dev_t;
	dev_t r;
	dev_t next_r;
	logic hold;
	logic button_low;
	logic button_fall;
	logic usb_rise;
	logic ac_rise;
	logic usb_level;
	logic ac_level;
	logic restart_low;
	logic undervoltage_lockout;
	logic overtemp_shutdown;
	logic pg_fail;
	logic wake_event;
	logic fault;
	logic button_expired;
	logic [`TIMER_WIDTH-1:0] hold_limit;
	logic [`TIMER_WIDTH-1:0] wake_limit;
	logic [`TIMER_WIDTH-1:0] second_limit;
	logic [6:0] pins;
	logic [6:0] pin_levels;
	logic [6:0] pin_rises;
	logic [6:0] pin_falls;
	logic [6:0] pin_idle;
	assign hold_limit = `TIMER_WIDTH'(`BUTTON_HOLD_CYCLES);
	assign wake_limit = `TIMER_WIDTH'(`WAKE_WINDOW_CYCLES);
	assign second_limit = `TIMER_WIDTH'(`SLEEP_DELAY_CYCLES);
	// ***********************************************
	// Input synchronisers.
	// ***********************************************
	assign pins = {LINK.power_hold_request, PUSH_BUTTON_IN, USB_INPUT,
		WALL_ADAPTER_INPUT, HARD_RESTART_N, UNDERVOLTAGE_LOCKOUT,
		OVERTEMP_SHUTDOWN};
	assign pin_idle = `PIN_IDLE_LEVELS;
	genvar g;
	generate
		for (g = 0; g < 7; g++) begin : gen_sync
			pin_sync u_sync (
				.CLOCK(CLOCK),
				.RESET_N(RESET_N),
				.PIN(pins[g]),
				.RESET_LEVEL(pin_idle[g]),
				.LEVEL(pin_levels[g]),
				.RISE(pin_rises[g]),
				.FALL(pin_falls[g])
			);
		end
	endgenerate
	assign hold = pin_levels[6];
	assign button_low = !pin_levels[5];
	assign button_fall = pin_falls[5];
	assign usb_level = pin_levels[4];
	assign usb_rise = pin_rises[4];
	assign ac_level = pin_levels[3];
	assign ac_rise = pin_rises[3];
	assign restart_low = !pin_levels[2];
	assign undervoltage_lockout = pin_levels[1];
	assign overtemp_shutdown = pin_levels[0];
	assign pg_fail = POWER_GOOD_FAIL;
	assign wake_event = button_fall || usb_rise || ac_rise;
	assign button_expired = button_low && (r.button_timer >= hold_limit);
	// Monitors are ignored while OFF and while waiting on a wake.
	assign fault = (r.state != ST_OFF) && (r.state != ST_WAKE_WAIT) &&
		(undervoltage_lockout || overtemp_shutdown || pg_fail);
	// ***********************************************
	// State machine.
	// ***********************************************
	always_comb begin
		next_r = r;
		next_r.regs_default = 1'b0;
		next_r.timer = r.timer + `TIMER_WIDTH'(1);
		// Button hold counter restarts every 8 s while held.
		if (!button_low || button_expired) begin
			next_r.button_timer = '0;
		end else begin
			next_r.button_timer = r.button_timer + `TIMER_WIDTH'(1);
		end
		unique case (r.state)
			ST_OFF: begin
				next_r.unseq_on = 1'b0;
				next_r.standby_on = 1'b0;
				next_r.seq_up = 1'b0;
				next_r.notify_low = 1'b0;
				next_r.regs_default = 1'b1;
				if (!(undervoltage_lockout || overtemp_shutdown || pg_fail)) begin
					next_r.fault_seen = 1'b0;
				end
				if (wake_event && !r.fault_seen) begin
					next_r.state = ST_WAKE_WAIT;
					next_r.timer = '0;
					next_r.unseq_on = 1'b1;
					next_r.standby_on = 1'b1;
					next_r.notify_low = 1'b1;
				end
			end
			ST_WAKE_WAIT: begin
				if (hold) begin
					next_r.state = ST_ACTIVE;
					next_r.notify_low = 1'b0;
					next_r.seq_up = 1'b1;
				end else if (r.timer >= wake_limit - `TIMER_WIDTH'(1)) begin
					next_r.state = ST_OFF;
					next_r.notify_low = 1'b0;
					next_r.unseq_on = 1'b0;
					next_r.standby_on = 1'b0;
					next_r.regs_default = 1'b1;
				end
			end
			ST_ACTIVE: begin
				next_r.notify_low = 1'b0;
				if (restart_low || button_expired) begin
					next_r.state = ST_RESET;
					next_r.timer = '0;
					next_r.seq_up = 1'b0;
					next_r.regs_default = 1'b1;
				end else if (!hold) begin
					next_r.state = ST_POWER_DOWN;
					next_r.timer = '0;
					next_r.seq_up = 1'b0;
				end
			end
			ST_POWER_DOWN: begin
				if (SHUTDOWN_SELECT) begin
					next_r.state = ST_OFF;
					next_r.unseq_on = 1'b0;
					next_r.standby_on = 1'b0;
					next_r.regs_default = 1'b1;
				end else if (r.timer >= second_limit - `TIMER_WIDTH'(1)) begin
					next_r.state = ST_SLEEP;
					next_r.standby_on = STANDBY_ENABLED;
					next_r.regs_default = 1'b1;
				end
			end
			ST_SLEEP: begin
				if (hold) begin
					next_r.state = ST_ACTIVE;
					next_r.seq_up = 1'b1;
				end else if (wake_event) begin
					next_r.state = ST_WAKE_WAIT;
					next_r.timer = '0;
					next_r.unseq_on = 1'b1;
					next_r.notify_low = 1'b1;
				end
			end
			ST_RESET: begin
				next_r.regs_default = 1'b1;
				if (SEQ_DOWN_DONE) begin
					next_r.unseq_on = 1'b0;
					next_r.standby_on = 1'b0;
				end
				if (restart_low) begin
					next_r.timer = r.timer;
				end
				if (!restart_low && SEQ_DOWN_DONE &&
					r.timer >= second_limit - `TIMER_WIDTH'(1)) begin
					next_r.state = ST_WAKE_WAIT;
					next_r.timer = '0;
					next_r.unseq_on = 1'b1;
					next_r.standby_on = 1'b1;
					next_r.notify_low = 1'b1;
				end
			end
		endcase
		// Faults override every path and latch until cleared.
		if (fault) begin
			next_r.state = ST_OFF;
			next_r.unseq_on = 1'b0;
			next_r.standby_on = 1'b0;
			next_r.seq_up = 1'b0;
			next_r.notify_low = 1'b0;
			next_r.fault_seen = 1'b1;
			next_r.regs_default = 1'b1;
		end
	end
	always_ff @(posedge CLOCK or negedge RESET_N) begin
		if (!RESET_N) begin
			r <= '{state: ST_OFF, fault_seen: 1'b0, regs_default: 1'b1,
				default: '0};
		end else begin
			r <= next_r;
		end
	end
	// ***********************************************
	// Outputs.
	// ***********************************************
	assign LINK.wake_notify_n_out = 1'b0;
	assign LINK.wake_notify_n_oe = r.notify_low;
	assign UNSEQUENCED_RAILS_ON = r.unseq_on;
	assign STANDBY_REGULATOR = r.standby_on;
	assign SEQ_POWER_UP = r.seq_up;
	assign SEQ_POWER_DOWN = !r.seq_up && (r.state != ST_OFF);
	assign REGISTERS_DEFAULT = r.regs_default;
	assign SERIAL_ENABLE = (r.state != ST_OFF);
	assign CHARGER_ACTIVE = CHARGER_ENABLE_REQ && (r.state != ST_OFF) &&
		(usb_level || ac_level);
	assign STATE = r.state;
endmodule : power_state_device
`default_nettype wire

/* File: hdl/power_hold_host.sv */
// Host end: drives power hold and watches the wake notification.
`timescale 1ns/1ns
`default_nettype none
`include "power_state_params.svh"
module power_hold_host
	import power_state_pkg::*;
(
	// Clock and reset.
	input wire logic CLOCK,
	input wire logic RESET_N,
	// Device link.
	power_hold_if.host LINK,
	// User side.
	input wire logic STAY_ON,
	output logic WAKE_SEEN
);
	typedef struct packed {
		logic meta;
		logic notify;
		logic hold;
		logic seen;
	} host_t;
	host_t r;
	host_t next_r;
	always_comb begin
		next_r = r;
		next_r.meta = LINK.wake_notify_n;
		next_r.notify = r.meta;
		next_r.seen = !r.notify;
		// Hold follows STAY_ON alone and does not answer a wake by itself; raises or
		// lowers hold on request to move between ACTIVE and SLEEP.
		next_r.hold = STAY_ON || (!r.notify && STAY_ON);
	end
	always_ff @(posedge CLOCK or negedge RESET_N) begin
		if (!RESET_N) begin
			r <= `HOST_LINK_RESET;
		end else begin
			r <= next_r;
		end
	end
	assign LINK.power_hold_request = r.hold;
	assign WAKE_SEEN = r.seen;
endmodule : power_hold_host
`default_nettype wire

/* File: verification/power_state_properties.sv */
// Checker on the link and state outputs of the power state controller.
`timescale 1ns/1ns
`default_nettype none
module power_state_properties
	import power_state_pkg::*;
(
	// Clock and reset.
	input wire logic CLOCK,
	input wire logic RESET_N,
	// Link signals.
	input wire logic power_hold_request,
	input wire logic wake_notify_n_oe,
	input wire logic wake_notify_n,
	// Device pins and outputs.
	input wire logic HARD_RESTART_N,
	input wire logic UNSEQUENCED_RAILS_ON,
	input wire logic SEQ_POWER_UP,
	input wire logic SEQ_POWER_DOWN,
	input wire logic REGISTERS_DEFAULT,
	input wire logic SERIAL_ENABLE,
	input wire power_state_t STATE
);
	default clocking cb @(posedge CLOCK);
	endclocking
	default disable iff (!RESET_N);
	notify_on_wake_a: assert property ($rose(wake_notify_n_oe) |->
		STATE == ST_WAKE_WAIT && UNSEQUENCED_RAILS_ON && !wake_notify_n)
		else $error("notify pulled without a wake");
	wait_notify_a: assert property (STATE == ST_WAKE_WAIT |->
		wake_notify_n_oe && !wake_notify_n)
		else $error("notify not low while waiting for hold");
	hold_enters_active_a: assert property (
		STATE == ST_WAKE_WAIT && $rose(power_hold_request) |->
		##[1:6] (STATE == ST_ACTIVE && !wake_notify_n_oe))
		else $error("hold did not lead to active");
	active_starts_seq_a: assert property (STATE == ST_ACTIVE |->
		SEQ_POWER_UP && !wake_notify_n_oe)
		else $error("active without sequencer start");
	active_exit_hold_a: assert property (
		STATE == ST_ACTIVE ##1 STATE == ST_POWER_DOWN |->
		!$past(power_hold_request, 3))
		else $error("left active while hold stayed high");
	power_down_seq_a: assert property (STATE == ST_POWER_DOWN |->
		SEQ_POWER_DOWN && !SEQ_POWER_UP)
		else $error("power down without sequencer");
	off_quiet_a: assert property (STATE == ST_OFF |->
		!UNSEQUENCED_RAILS_ON && REGISTERS_DEFAULT && !SERIAL_ENABLE)
		else $error("off state not quiet");
	reset_defaults_a: assert property (STATE == ST_RESET |->
		REGISTERS_DEFAULT && !SEQ_POWER_UP)
		else $error("reset state without defaults");
	reset_holds_a: assert property (
		STATE == ST_RESET && !$past(HARD_RESTART_N, 2) |=> STATE == ST_RESET)
		else $error("reset left while restart low");
endmodule : power_state_properties
`default_nettype wire

/* File: verification/pmic_power_state_controller_tb.sv */
// Self-checking bench for both ends of the power state controller.
`timescale 1ns/1ns
`default_nettype none
module pmic_power_state_controller_tb
	import power_state_pkg::*;
;
	typedef struct packed {
		logic [2:0] ev;
		logic undervoltage_lockout;
		power_state_t st;
	} row_t;
	logic CLOCK = 1'h0, RESET_N = 1'h0, PUSH_BUTTON_IN = 1'h1, USB_INPUT = 1'h0;
	logic WALL_ADAPTER_INPUT = 1'h0, HARD_RESTART_N = 1'h1, STAY_ON = 1'h0;
	logic UNDERVOLTAGE_LOCKOUT = 1'h0, OVERTEMP_SHUTDOWN = 1'h0;
	logic SHUTDOWN_SELECT = 1'h0, SEQ_DOWN_DONE = 1'h0;
	logic POWER_GOOD_FAIL = 1'h0, STANDBY_ENABLED = 1'h0;
	logic CHARGER_ENABLE_REQ = 1'h0;
	logic UNSEQUENCED_RAILS_ON, SEQ_POWER_UP, SEQ_POWER_DOWN, WAKE_SEEN;
	logic REGISTERS_DEFAULT, SERIAL_ENABLE;
	logic STANDBY_REGULATOR, CHARGER_ACTIVE;
	power_state_t STATE;
	int err_count = 0, tests_run = 0, cycles = 0;
	row_t rows [5] = '{'{3'h4, 1'h0, ST_WAKE_WAIT}, '{3'h2, 1'h0, ST_WAKE_WAIT},
		'{3'h1, 1'h0, ST_WAKE_WAIT}, '{3'h4, 1'h1, ST_WAKE_WAIT},
		'{3'h0, 1'h0, ST_OFF}};
	power_hold_if link();
	power_state_device power_state_device_inst (.CLOCK(CLOCK),
		.RESET_N(RESET_N), .LINK(link.device), .PUSH_BUTTON_IN(PUSH_BUTTON_IN),
		.USB_INPUT(USB_INPUT), .WALL_ADAPTER_INPUT(WALL_ADAPTER_INPUT),
		.HARD_RESTART_N(HARD_RESTART_N),
		.UNDERVOLTAGE_LOCKOUT(UNDERVOLTAGE_LOCKOUT),
		.OVERTEMP_SHUTDOWN(OVERTEMP_SHUTDOWN), .POWER_GOOD_FAIL(POWER_GOOD_FAIL),
		.SHUTDOWN_SELECT(SHUTDOWN_SELECT), .STANDBY_ENABLED(STANDBY_ENABLED),
		.SEQ_DOWN_DONE(SEQ_DOWN_DONE), .CHARGER_ENABLE_REQ(CHARGER_ENABLE_REQ),
		.UNSEQUENCED_RAILS_ON(UNSEQUENCED_RAILS_ON),
		.STANDBY_REGULATOR(STANDBY_REGULATOR),
		.SEQ_POWER_UP(SEQ_POWER_UP), .SEQ_POWER_DOWN(SEQ_POWER_DOWN),
		.REGISTERS_DEFAULT(REGISTERS_DEFAULT), .SERIAL_ENABLE(SERIAL_ENABLE),
		.CHARGER_ACTIVE(CHARGER_ACTIVE), .STATE(STATE));
	power_hold_host power_hold_host_inst (.CLOCK(CLOCK), .RESET_N(RESET_N),
		.LINK(link.host), .STAY_ON(STAY_ON), .WAKE_SEEN(WAKE_SEEN));
	power_state_properties power_state_properties_inst (.CLOCK(CLOCK),
		.RESET_N(RESET_N), .power_hold_request(link.power_hold_request),
		.wake_notify_n_oe(link.wake_notify_n_oe),
		.wake_notify_n(link.wake_notify_n), .HARD_RESTART_N(HARD_RESTART_N),
		.UNSEQUENCED_RAILS_ON(UNSEQUENCED_RAILS_ON), .SEQ_POWER_UP(SEQ_POWER_UP),
		.SEQ_POWER_DOWN(SEQ_POWER_DOWN), .REGISTERS_DEFAULT(REGISTERS_DEFAULT),
		.SERIAL_ENABLE(SERIAL_ENABLE), .STATE(STATE));
	// ****************************************
	// Clock, timeout and shared tasks.
	// ****************************************
	initial begin
		forever #20 CLOCK = ~CLOCK;
	end
	always @(posedge CLOCK) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			close_out();
		end
	end
	task close_out;
		if (err_count == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : close_out
	task check(input logic [2:0] seen, input logic [2:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("FAIL %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task tick;
		@(posedge CLOCK);
		#1;
	endtask : tick
	task wait_state(input power_state_t s);
		for (int i = 0; i < 60 && STATE !== s; i++)
			tick();
	endtask : wait_state
	task do_reset;
		RESET_N = 1'h0;
		{USB_INPUT, WALL_ADAPTER_INPUT, UNDERVOLTAGE_LOCKOUT} = 3'h0;
		{STAY_ON, OVERTEMP_SHUTDOWN, SEQ_DOWN_DONE, SHUTDOWN_SELECT} = 4'h0;
		{PUSH_BUTTON_IN, HARD_RESTART_N} = 2'h3;
		repeat (12) tick();
		RESET_N = 1'h1;
		repeat (4) tick();
	endtask : do_reset
	task wake_up;
		USB_INPUT = 1'h1;
		wait_state(ST_WAKE_WAIT);
		STAY_ON = 1'h1;
		wait_state(ST_ACTIVE);
	endtask : wake_up
	// ****************************************
	// Wake events from OFF, then awkward cases.
	// ****************************************
	initial begin
		for (int r = 0; r < 5; r++) begin
			do_reset();
			UNDERVOLTAGE_LOCKOUT = rows[r].undervoltage_lockout;
			{USB_INPUT, WALL_ADAPTER_INPUT} = rows[r].ev[2:1];
			PUSH_BUTTON_IN = !rows[r].ev[0];
			wait_state(rows[r].st);
			repeat (4) tick();
			check(STATE, rows[r].st);
			check(3'(link.wake_notify_n), 3'(rows[r].st == ST_OFF));
			check(3'(UNSEQUENCED_RAILS_ON), 3'(rows[r].st != ST_OFF));
		end
		check(3'(REGISTERS_DEFAULT), 3'h1);
		check(3'(SERIAL_ENABLE), 3'h0);
		do_reset();
		wake_up();
		check(STATE, ST_ACTIVE);
		check(3'(link.wake_notify_n_oe), 3'h0);
		check(3'(SEQ_POWER_UP), 3'h1);
		check(3'(WAKE_SEEN), 3'h1);
		check(3'(STANDBY_REGULATOR), 3'h1);
		CHARGER_ENABLE_REQ = 1'h1;
		tick();
		check(3'(CHARGER_ACTIVE), 3'h1);
		USB_INPUT = 1'h0;
		SHUTDOWN_SELECT = 1'h1;
		repeat (10) tick();
		check(STATE, ST_ACTIVE);
		check(3'(CHARGER_ACTIVE), 3'h0);
		SEQ_DOWN_DONE = 1'h1;
		STAY_ON = 1'h0;
		wait_state(ST_POWER_DOWN);
		check(3'(SEQ_POWER_DOWN), 3'h1);
		wait_state(ST_OFF);
		check(STATE, ST_OFF);
		check(3'(STANDBY_REGULATOR), 3'h0);
		wake_up();
		OVERTEMP_SHUTDOWN = 1'h1;
		wait_state(ST_OFF);
		check(STATE, ST_OFF);
		check(3'(UNSEQUENCED_RAILS_ON), 3'h0);
		USB_INPUT = 1'h0;
		repeat (4) tick();
		USB_INPUT = 1'h1;
		repeat (10) tick();
		check(STATE, ST_OFF);
		OVERTEMP_SHUTDOWN = 1'h0;
		USB_INPUT = 1'h0;
		repeat (4) tick();
		USB_INPUT = 1'h1;
		wait_state(ST_WAKE_WAIT);
		check(STATE, ST_WAKE_WAIT);
		do_reset();
		wake_up();
		HARD_RESTART_N = 1'h0;
		wait_state(ST_RESET);
		check(STATE, ST_RESET);
		check(3'(REGISTERS_DEFAULT), 3'h1);
		SEQ_DOWN_DONE = 1'h1;
		repeat (20) tick();
		check(STATE, ST_RESET);
		close_out();
	end
endmodule : pmic_power_state_controller_tb
`default_nettype wire
